// >>> common/tpc_pkg.sv
package tpc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] TPC_ADDR_CFG = 8'h78;
	localparam logic [7:0] TPC_ADDR_TMR_STATUS = 8'h79;
	localparam logic [7:0] TPC_ADDR_TMR_LIMIT = 8'h7a;
	localparam logic [7:0] TPC_CFG_RESET = 8'h00;
	localparam logic [7:0] TPC_STATUS_RESET = 8'h00;
	localparam logic [7:0] TPC_LIMIT_RESET = 8'h00;
	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	localparam int TPC_BIT_ALERT = 0;
	localparam int TPC_BIT_OVH_EN = 1;
	localparam int TPC_BIT_MAX_DUTY_ON_HOT = 2;
	localparam int TPC_BIT_FAST = 3;
	localparam int TPC_BIT_DC_LO = 4;
	localparam logic [1:0] TPC_P14_FAN4_SPEED_IN = 2'h0;
	localparam logic [1:0] TPC_P14_OVH = 2'h1;
	localparam logic [1:0] TPC_P14_ALERT = 2'h2;
	localparam logic [1:0] TPC_P14_GPIO = 2'h3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int TPC_CLK_HZ = 25000000;
	localparam real TPC_TICK_US = 22760.0;
	localparam int TPC_TICK_CYC = int'(TPC_TICK_US * TPC_CLK_HZ / 1000000.0);
	localparam real TPC_FAST_MS = 250.0;
	localparam int TPC_FAST_CYC = int'(TPC_FAST_MS * TPC_CLK_HZ / 1000.0);
	localparam real TPC_SLOW_MS = 1000.0;
	localparam int TPC_SLOW_CYC = int'(TPC_SLOW_MS * TPC_CLK_HZ / 1000.0);
	localparam logic [7:0] TPC_TMR_MAX = 8'hff;
	localparam logic [7:0] TPC_TMR_FIRST = 8'h02;
endpackage

// >>> hw/tpc_tick.sv
`timescale 1ns/10ps
`default_nettype none
module tpc_tick
	import tpc_pkg::*;
#(
	parameter int PERIOD = 16
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Control
	input wire logic run_in,
	output logic tick_out
);
	logic [31:0] count;
	wire last = count == 32'(PERIOD - 1);
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			count <= 32'h0;
		else if (!run_in || last)
			count <= 32'h0;
		else
			count <= count + 32'h1;
	end
	assign tick_out = run_in && last;
endmodule
`default_nettype wire

// >>> hw/tpc_pinmux.sv
`timescale 1ns/10ps
`default_nettype none
module tpc_pinmux
	import tpc_pkg::*;
(
	// Configuration
	input wire logic alert_sel_in,
	input wire logic ovh_en_in,
	input wire logic [1:0] p14_sel_in,
	// Function routing
	output logic p10_alert_out,
	output logic p22_ovh_out,
	output logic p14_fan4_speed_in_out,
	output logic p14_ovh_out,
	output logic p14_alert_out,
	output logic p14_gpio_out
);
	assign p10_alert_out = alert_sel_in;
	assign p22_ovh_out = ovh_en_in && (p14_sel_in != TPC_P14_OVH);
	assign p14_fan4_speed_in_out = p14_sel_in == TPC_P14_FAN4_SPEED_IN;
	assign p14_ovh_out = p14_sel_in == TPC_P14_OVH;
	assign p14_alert_out = p14_sel_in == TPC_P14_ALERT;
	assign p14_gpio_out = p14_sel_in == TPC_P14_GPIO;
endmodule
`default_nettype wire

// >>> hw/tpc_top.sv
`timescale 1ns/10ps
`default_nettype none
module tpc_top
	import tpc_pkg::*;
#(
	parameter int TICK_CYC = TPC_TICK_CYC,
	parameter int FAST_CYC = TPC_FAST_CYC,
	parameter int SLOW_CYC = TPC_SLOW_CYC
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Config register lock and pin fourteen field
	input wire logic cfg_lock_in,
	input wire logic [1:0] pin_fourteen_select_in,
	// Overheat line
	input wire logic overheat_pin_in,
	input wire logic overheat_drive_in,
	output logic overheat_pin_out,
	output logic overheat_pin_oe_n_out,
	// Pin routing
	output logic fan2_drive_sel_out,
	output logic alert_p10_sel_out,
	output logic overheat_p22_sel_out,
	output logic fan4_speed_sel_out,
	output logic overheat_p14_sel_out,
	output logic alert_p14_sel_out,
	output logic general_io_six_sel_out,
	// Fan control
	output logic fans_full_out,
	output logic fans_max_duty_out,
	output logic tach_sample_out,
	output logic [3:0] fan_steady_sense_out,
	// Fault event
	output logic fan4_or_timer_fault_out
);
	typedef enum logic [2:0] {
		TPC_IDLE = 3'b001,
		TPC_TIMING = 3'b010,
		TPC_LONG = 3'b100
	} tpc_state_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] pin_and_tach_config;
	logic [7:0] assert_time_ceiling;
	logic assert_seen_flag;
	logic [7:0] assert_time_count;
	logic ceiling_tripped;
	tpc_state_t state;
	tpc_state_t next_state;
	logic [7:0] next_count;
	logic [7:0] rdata;
	logic fault;
	logic ovh_dly;

	wire cfg_hit = reg_addr_in == TPC_ADDR_CFG;
	wire sts_hit = reg_addr_in == TPC_ADDR_TMR_STATUS;
	wire lim_hit = reg_addr_in == TPC_ADDR_TMR_LIMIT;
	wire cfg_wr = reg_wr_in && cfg_hit && !cfg_lock_in;
	wire sts_rd = reg_rd_in && sts_hit;
	wire alert_sel = pin_and_tach_config[TPC_BIT_ALERT];
	wire ovh_en = pin_and_tach_config[TPC_BIT_OVH_EN];
	wire max_duty_on_hot = pin_and_tach_config[TPC_BIT_MAX_DUTY_ON_HOT];
	wire fast = pin_and_tach_config[TPC_BIT_FAST];
	wire [3:0] steady = pin_and_tach_config[TPC_BIT_DC_LO +: 4];

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	logic p22_ovh;
	logic p14_ovh;
	tpc_pinmux u_pinmux (
		.alert_sel_in(alert_sel),
		.ovh_en_in(ovh_en),
		.p14_sel_in(pin_fourteen_select_in),
		.p10_alert_out(alert_p10_sel_out),
		.p22_ovh_out(p22_ovh),
		.p14_fan4_speed_in_out(fan4_speed_sel_out),
		.p14_ovh_out(p14_ovh),
		.p14_alert_out(alert_p14_sel_out),
		.p14_gpio_out(general_io_six_sel_out)
	);
	assign overheat_p22_sel_out = p22_ovh;
	assign overheat_p14_sel_out = p14_ovh;
	assign fan2_drive_sel_out = !alert_sel;
	wire ovh_avail = p22_ovh || p14_ovh;

	// ----------------------------------------
	// Overheat line handling
	// ----------------------------------------
	wire ovh_driving = ovh_avail && overheat_drive_in;
	assign overheat_pin_out = 1'b0;
	assign overheat_pin_oe_n_out = !ovh_driving;
	wire ovh_asserted = ovh_avail && !ovh_driving && !overheat_pin_in;
	wire ovh_rise = ovh_asserted && !ovh_dly;
	assign fans_full_out = ovh_driving;
	assign fans_max_duty_out = ovh_asserted && max_duty_on_hot;

	// ----------------------------------------
	// Tach sampling
	// ----------------------------------------
	logic tick_fast;
	logic tick_slow;
	tpc_tick #(.PERIOD(FAST_CYC)) u_fast (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.run_in(fast),
		.tick_out(tick_fast)
	);
	tpc_tick #(.PERIOD(SLOW_CYC)) u_slow (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.run_in(!fast),
		.tick_out(tick_slow)
	);
	assign tach_sample_out = tick_fast || tick_slow;
	assign fan_steady_sense_out = steady;

	// ----------------------------------------
	// Assertion timer
	// ----------------------------------------
	logic tick_tmr;
	tpc_tick #(.PERIOD(TICK_CYC)) u_tmr (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.run_in(ovh_asserted),
		.tick_out(tick_tmr)
	);
	wire [7:0] inc_count = (assert_time_count == TPC_TMR_MAX) ?
		assert_time_count : assert_time_count + 8'h1;
	always_comb begin
		next_state = state;
		next_count = assert_time_count;
		case (state)
			TPC_IDLE: begin
				if (ovh_rise) begin
					next_state = TPC_TIMING;
					next_count = 8'h0;
				end
			end
			TPC_TIMING: begin
				if (!ovh_asserted)
					next_state = TPC_IDLE;
				else if (tick_tmr) begin
					next_count = inc_count;
					if (inc_count == TPC_TMR_FIRST)
						next_state = TPC_LONG;
				end
			end
			TPC_LONG: begin
				if (!ovh_asserted)
					next_state = TPC_IDLE;
				else if (tick_tmr)
					next_count = inc_count;
			end
			default: next_state = TPC_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= TPC_IDLE;
			assert_time_count <= 8'h0;
			ovh_dly <= 1'b0;
		end else begin
			state <= next_state;
			assert_time_count <= next_count;
			ovh_dly <= ovh_asserted;
		end
	end
	wire long_seen = assert_time_count >= TPC_TMR_FIRST;
	// Set wins over read-clear
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			assert_seen_flag <= 1'b0;
		else if (ovh_rise)
			assert_seen_flag <= 1'b1;
		else if (sts_rd)
			assert_seen_flag <= 1'b0;
	end
	wire [7:0] status_view = long_seen ? assert_time_count :
		{7'h0, assert_seen_flag};

	// ----------------------------------------
	// Ceiling fault
	// ----------------------------------------
	// Count is stale until the timer has restarted
	wire count_live = state != TPC_IDLE;
	wire over_ceiling = ovh_asserted && !ceiling_tripped &&
		(assert_time_ceiling == 8'h0 ||
		(count_live && assert_time_count > assert_time_ceiling));
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ceiling_tripped <= 1'b0;
			fault <= 1'b0;
		end else begin
			fault <= over_ceiling;
			if (!ovh_asserted)
				ceiling_tripped <= 1'b0;
			else if (over_ceiling)
				ceiling_tripped <= 1'b1;
		end
	end
	assign fan4_or_timer_fault_out = fault;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_and_tach_config <= TPC_CFG_RESET;
			assert_time_ceiling <= TPC_LIMIT_RESET;
		end else begin
			if (cfg_wr)
				pin_and_tach_config <= reg_wdata_in;
			if (reg_wr_in && lim_hit)
				assert_time_ceiling <= reg_wdata_in;
		end
	end
	wire [7:0] rd_mux = cfg_hit ? pin_and_tach_config :
		sts_hit ? status_view :
		lim_hit ? assert_time_ceiling : TPC_STATUS_RESET;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rdata <= 8'h0;
		else if (reg_rd_in)
			rdata <= rd_mux;
	end
	assign reg_rdata_out = rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_lock_holds: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(reg_wr_in && cfg_hit && cfg_lock_in) |=> $stable(pin_and_tach_config))
		else $error("config changed while locked");
	a_flag_set: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		ovh_rise |=> assert_seen_flag)
		else $error("assert flag not set");
	a_flag_clear: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(sts_rd && !ovh_rise) |=> !assert_seen_flag)
		else $error("assert flag not cleared");
	a_upper_zero: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(sts_rd && assert_time_count < TPC_TMR_FIRST) |=> reg_rdata_out[7:1] == 7'h0)
		else $error("timer bits early");
	a_count_step: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(state != TPC_IDLE && ovh_asserted && tick_tmr && assert_time_count != TPC_TMR_MAX)
		|=> assert_time_count == $past(assert_time_count) + 8'h1)
		else $error("count did not step");
	a_long_entry: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(state == TPC_TIMING && ovh_asserted && tick_tmr &&
		assert_time_count == TPC_TMR_FIRST - 8'h1) |=> state == TPC_LONG)
		else $error("long timing not entered");
	a_zero_ceiling: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(ovh_rise && assert_time_ceiling == 8'h0) |=> fault)
		else $error("zero ceiling did not trip");
	a_fresh_count: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(ovh_rise && assert_time_ceiling != 8'h0) |=> !fault)
		else $error("fault from stale count");
	a_max_duty_on_hot_duty: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(!overheat_pin_in && !overheat_drive_in && overheat_p22_sel_out && max_duty_on_hot)
		|-> fans_max_duty_out)
		else $error("max_duty_on_hot missing");
	a_full_drive: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(overheat_drive_in && overheat_p22_sel_out) |-> (fans_full_out && !overheat_pin_oe_n_out))
		else $error("full speed missing while driving");
	a_p22_route: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(pin_fourteen_select_in == TPC_P14_OVH) |-> !overheat_p22_sel_out)
		else $error("pin22 misrouted");
	a_p14_onehot: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		$onehot({fan4_speed_sel_out, overheat_p14_sel_out, alert_p14_sel_out, general_io_six_sel_out}))
		else $error("pin14 function not unique");
	a_alert_route: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(alert_p10_sel_out == alert_sel) && (fan2_drive_sel_out == !alert_sel))
		else $error("pin10 misrouted");
	a_tach_pulse: assert property (
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		tach_sample_out |=> !tach_sample_out)
		else $error("tach strobe too long");
	c_long: cover property (@(posedge clk_sys_in) state == TPC_LONG);
	c_fault: cover property (@(posedge clk_sys_in) fault);
	c_read_clear: cover property (@(posedge clk_sys_in) sts_rd && assert_seen_flag);
	c_zero_ceiling: cover property (@(posedge clk_sys_in) ovh_rise && assert_time_ceiling == 8'h0);
	c_lock_write: cover property (@(posedge clk_sys_in) reg_wr_in && cfg_hit && cfg_lock_in);
endmodule
`default_nettype wire

// >>> tb/tpc_ovh_src.sv
`timescale 1ns/10ps
`default_nettype none
module tpc_ovh_src (
	// Source control
	input wire logic hold_low_in,
	// Device side of the line
	input wire logic dut_oe_n_in,
	input wire logic dut_level_in,
	// Resolved line
	output logic line_out
);
	// Open drain with pull-up: released line reads high
	assign line_out = hold_low_in ? 1'b0 : (!dut_oe_n_in ? dut_level_in : 1'b1);
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tpc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys_in = 0, reset_n_in = 0, wr = 0, rd = 0, lock = 0, hold = 0, drive = 0;
	logic [7:0] addr = 0, wdata = 0, v = 0;
	logic [1:0] p14 = 0;
	logic [7:0] rdata;
	logic pin_lvl, oe_n, line, s_f2, s_a10, s_o22, s_t4, s_o14, s_a14, s_g6;
	logic full, maxd, tach, fault, rd_d = 0;
	logic [3:0] steady;
	logic [7:0] exp_q[$];
	int n_mismatch = 0, check_count = 0, n_fault = 0, f0 = 0, g = 0;
	logic [7:0] ceil_tab[3] = '{8'h00, 8'h03, 8'h06};
	int pulse_tab[3] = '{1, 1, 0};
	always #20 clk_sys_in = ~clk_sys_in;
	tpc_top #(.TICK_CYC(10), .FAST_CYC(20), .SLOW_CYC(40)) dut (.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .cfg_lock_in(lock), .pin_fourteen_select_in(p14),
		.overheat_pin_in(line), .overheat_drive_in(drive), .overheat_pin_out(pin_lvl),
		.overheat_pin_oe_n_out(oe_n), .fan2_drive_sel_out(s_f2), .alert_p10_sel_out(s_a10),
		.overheat_p22_sel_out(s_o22), .fan4_speed_sel_out(s_t4), .overheat_p14_sel_out(s_o14),
		.alert_p14_sel_out(s_a14), .general_io_six_sel_out(s_g6), .fans_full_out(full),
		.fans_max_duty_out(maxd), .tach_sample_out(tach), .fan_steady_sense_out(steady),
		.fan4_or_timer_fault_out(fault));
	tpc_ovh_src src (.hold_low_in(hold), .dut_oe_n_in(oe_n), .dut_level_in(pin_lvl),
		.line_out(line));
	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys_in);
		rd <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic tach_gap(output int gap);
		do @(posedge clk_sys_in); while (tach !== 1'b1);
		gap = 0;
		do begin
			@(posedge clk_sys_in);
			gap++;
		end while (tach !== 1'b1);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge clk_sys_in) begin
		rd_d <= rd;
		if (rd_d && exp_q.size() > 0) chk8(rdata, exp_q.pop_front(), "read data");
		if (fault === 1'b1) n_fault++;
	end
	initial begin
		#400000;
		n_mismatch++;
		summarize();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'he080));
		cyc(10);
		reset_n_in <= 1'b1;
		cyc(1);
		rd_reg(TPC_ADDR_CFG, TPC_CFG_RESET);
		rd_reg(TPC_ADDR_TMR_STATUS, TPC_STATUS_RESET);
		rd_reg(TPC_ADDR_TMR_LIMIT, TPC_LIMIT_RESET);
		rd_reg(8'h55, 8'h00);
		cyc(3);
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			v = {4'($urandom), 2'h0, i[1], i[0]};
			p14 <= i[3:2];
			wr_reg(TPC_ADDR_CFG, v);
			cyc(1);
			chk(s_f2, ~v[0], "fan two drive select");
			chk(s_a10, v[0], "pin ten alert select");
			chk(s_o22, v[1] && (p14 != TPC_P14_OVH), "pin 22 overheat select");
			chk(s_t4, p14 == TPC_P14_FAN4_SPEED_IN, "tach four select");
			chk(s_o14, p14 == TPC_P14_OVH, "pin 14 overheat select");
			chk(s_a14, p14 == TPC_P14_ALERT, "pin 14 alert select");
			chk(s_g6, p14 == TPC_P14_GPIO, "general io six select");
			chk8({4'h0, steady}, {4'h0, v[7:4]}, "steady sense bits");
			rd_reg(TPC_ADDR_CFG, v);
		end
		p14 <= TPC_P14_FAN4_SPEED_IN;
		lock <= 1'b1;
		wr_reg(TPC_ADDR_CFG, ~v);
		cyc(1);
		rd_reg(TPC_ADDR_CFG, v);
		lock <= 1'b0;
		$display("pin routing and lock done");
		wr_reg(TPC_ADDR_CFG, 8'h08);
		tach_gap(g);
		tach_gap(g);
		chk8(8'(g), 8'd20, "fast tach interval");
		wr_reg(TPC_ADDR_CFG, 8'h00);
		tach_gap(g);
		tach_gap(g);
		chk8(8'(g), 8'd40, "slow tach interval");
		$display("tach rate done");
		wr_reg(TPC_ADDR_TMR_LIMIT, 8'h06);
		wr_reg(TPC_ADDR_CFG, 8'h06);
		hold <= 1'b1;
		cyc(3);
		chk(maxd, 1'b1, "max duty while hot");
		cyc(12);
		rd_reg(TPC_ADDR_TMR_STATUS, 8'h01);
		hold <= 1'b0;
		cyc(2);
		chk(maxd, 1'b0, "max duty after release");
		rd_reg(TPC_ADDR_TMR_STATUS, 8'h00);
		for (int c = 0; c < 3; c++) begin
			wr_reg(TPC_ADDR_TMR_LIMIT, ceil_tab[c]);
			f0 = n_fault;
			hold <= 1'b1;
			cyc(20);
			chk8(8'(n_fault - f0), 8'(c == 0), "early fault pulses");
			cyc(35);
			hold <= 1'b0;
			cyc(3);
			rd_reg(TPC_ADDR_TMR_STATUS, 8'h05);
			chk8(8'(n_fault - f0), 8'(pulse_tab[c]), "fault pulses");
		end
		$display("assertion timer done");
		drive <= 1'b1;
		cyc(2);
		chk(full, 1'b1, "full speed when driving");
		chk(oe_n, 1'b0, "line driven");
		chk(pin_lvl, 1'b0, "line level driven low");
		drive <= 1'b0;
		cyc(2);
		chk(full, 1'b0, "full speed released");
		$display("overheat output done");
		cyc(4);
		summarize();
	end
endmodule
`default_nettype wire
